// ### include/sas_pkg.sv
package sas_pkg;
  // Clock and sampling time base
  localparam int CLK_HZ = 50_000_000;
  localparam int BASE_HZ = 1_280_000;
  // Fractional divider: add STEP, wrap at MOD (ratio kept exact)
  localparam logic [12:0] BASE_STEP = 13'(BASE_HZ / 10_000);
  localparam logic [12:0] BASE_MOD = 13'(CLK_HZ / 10_000);
  // Manual conversion periods in base ticks
  localparam int RATE80_HZ = 80_000;
  localparam int RATE160_HZ = 160_000;
  localparam int RATE320_HZ = 320_000;
  localparam logic [6:0] TICKS_80K = 7'(BASE_HZ / RATE80_HZ);
  localparam logic [6:0] TICKS_160K = 7'(BASE_HZ / RATE160_HZ);
  localparam logic [6:0] TICKS_320K = 7'(BASE_HZ / RATE320_HZ);
  // Sweep sample time: base + STEP * field
  localparam logic [6:0] ST_BASE_320K = 7'h02;
  localparam logic [6:0] ST_BASE_256K = 7'h03;
  localparam int ST_STEP_SHIFT = 2;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CFG_TEMP_PGA = 12'h06c;
  localparam logic [11:0] OFS_CFG_GROUP_A = 12'h070;
  localparam logic [11:0] OFS_CFG_GROUP_B = 12'h074;
  localparam logic [11:0] OFS_CFG_GROUP_C = 12'h078;
  localparam logic [11:0] OFS_SAMPLES = 12'h800;
  // Control register fields
  localparam int CTRL_OVERRIDE = 0;
  localparam int CTRL_ENABLE = 1;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_PAIR_LSB = 4;
  localparam int CTRL_SINGLE = 7;
  localparam int CTRL_NEG = 8;
  localparam int CTRL_MAX256 = 9;
  localparam logic CTRL_OVERRIDE_RST = 1'b1;
  localparam logic [1:0] CTRL_RATE_RST = 2'h2;
  // Channel configuration fields
  localparam int CFG_EN = 4;
  localparam int CFG_DIFF = 5;
  localparam int CFG_ONESHOT = 6;
  localparam int CFG_BITS = 7;
  localparam int STATUS_BUSY = 16;
  // Sample regions
  localparam int REGION_BYTES = 128;
  localparam int SAMPLE_BYTES = 2;
  localparam int REGION_WORDS = REGION_BYTES / SAMPLE_BYTES;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer phases
  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_CONV} sas_phase_type;
endpackage

// ### hw/sas_top.sv
// Overview of operation
// - Reset leaves controller in manual mode
// - Manual rate selects 80k, 160k or 320k
// - Manual picks pair, differential or single polarity
// - Differential input is the reset default
// - Enabled controller samples repeatedly into channel region
// - 128-byte region per channel, flag when full
// - Each 12-bit result fills two bytes
// - Override bit 0 clear selects automatic sweep
// - Sweep writes the same per-channel regions
// - Sixteen-bit channel configs, two per register
// - At 256k maximum, 3T to 63T
// - Config bit 4 enables channel in sweep
// - Config bit 5 differential, else single-ended
// - Config bit 6 one-shot, else continuous
// - Channel configs act only in sweep mode
module sas_top #(
  parameter int CHANNELS = 8,
  parameter int DATA_BITS = 12
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // AXI4-Lite write address and data
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Converter core request
  output logic CONV_START,
  output logic [2:0] CONV_CHAN,
  output logic CONV_DIFF,
  output logic CONV_NEG,
  // Converter core result, same clock domain
  input wire logic CONV_VALID,
  input wire logic [DATA_BITS-1:0] CONV_DATA,
  output logic CONV_READY
);
  localparam int IW = $clog2(sas_pkg::REGION_WORDS);
  localparam int EW = 3 + DATA_BITS;
  localparam int CFG_BITS_L = sas_pkg::CFG_BITS; // Kept bits of a config

  // Whole state of the block except the sample storage in one record
  typedef struct packed {
    logic aw_full;                       // Write address held
    logic [11:0] aw_addr;
    logic w_full;                        // Write data held
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic override;                      // 1 manual, 0 sweep
    logic enable;
    logic [1:0] rate;
    logic [2:0] pair;
    logic single;
    logic neg;
    logic max256;
    logic [7:0][CFG_BITS_L-1:0] cfg;     // Per-channel sweep config
    logic [7:0] full;                    // Sticky region-full flags
    logic [7:0] done;                    // One-shot channels finished
    logic [7:0][IW-1:0] widx;            // Write index per region
    logic [12:0] acc;                    // Base tick accumulator
    logic tick;
    sas_pkg::sas_phase_type phase;
    logic [2:0] chan;
    logic diff;
    logic nsel;
    logic [6:0] cnt;
    logic start;
    logic [1:0][EW-1:0] buf_d;           // Two-entry result buffer
    logic buf_head;
    logic [1:0] buf_cnt;
    logic conv_ready;
  } sas_state_type;

  sas_state_type r;
  sas_state_type next_r;

  // Sample storage, one 16-bit word per result
  logic [15:0] mem [0:8*sas_pkg::REGION_WORDS-1];
  logic mem_we;
  logic [IW+2:0] mem_wa;
  logic [15:0] mem_wd;
  logic [IW+2:0] mem_ra;

  // Merge a written word into an old value under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Next enabled, unfinished channel after the current one
  function automatic logic [3:0] pick(input logic [7:0][CFG_BITS_L-1:0] c,
      input logic [7:0] dn, input logic [2:0] cur);
    logic [3:0] res;
    logic [2:0] k;
    res = 4'h0;
    for (int i = 8; i >= 1; i--) begin
      k = 3'(cur + 3'(i));
      if (c[k][sas_pkg::CFG_EN] && !dn[k]) begin
        res = {1'b1, k};
      end
    end
    return res;
  endfunction

  // Register image of a 32-bit configuration word
  function automatic logic [31:0] cfg_word(
      input logic [7:0][CFG_BITS_L-1:0] c, input int g);
    return {9'h000, c[2*g+1], 9'h000, c[2*g]};
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic [31:0] ctrl_word;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [1:0] rr;
    logic rd_mem;
    logic push;
    logic pop;
    logic [3:0] nx;
    logic [6:0] st_base;
    logic [EW-1:0] head;
    logic [2:0] hc;
    int g;
    ctrl_word = 32'h0;
    wv = 32'h0;
    rv = 32'h0;
    rr = sas_pkg::RESP_OKAY;
    rd_mem = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    nx = 4'h0;
    st_base = 7'h0;
    head = r.buf_d[r.buf_head];
    hc = head[EW-1 -: 3];
    g = 0;
    next_r = r;
    next_r.start = 1'b0;
    mem_we = 1'b0;
    mem_wa = {hc, r.widx[hc]};
    mem_wd = 16'(head[DATA_BITS-1:0]);
    mem_ra = S_AXI_ARADDR[IW+4:2];

    ctrl_word[sas_pkg::CTRL_OVERRIDE] = r.override;
    ctrl_word[sas_pkg::CTRL_ENABLE] = r.enable;
    ctrl_word[sas_pkg::CTRL_RATE_LSB +: 2] = r.rate;
    ctrl_word[sas_pkg::CTRL_PAIR_LSB +: 3] = r.pair;
    ctrl_word[sas_pkg::CTRL_SINGLE] = r.single;
    ctrl_word[sas_pkg::CTRL_NEG] = r.neg;
    ctrl_word[sas_pkg::CTRL_MAX256] = r.max256;

    // Base tick at 1.28 MHz from an exact fractional divider
    if (r.acc + sas_pkg::BASE_STEP >= sas_pkg::BASE_MOD) begin
      next_r.acc = r.acc + sas_pkg::BASE_STEP - sas_pkg::BASE_MOD;
      next_r.tick = 1'b1;
    end else begin
      next_r.acc = r.acc + sas_pkg::BASE_STEP;
      next_r.tick = 1'b0;
    end

    // Capture write address and data in either order
    if (S_AXI_AWVALID && r.awready) begin
      next_r.aw_full = 1'b1;
      next_r.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && r.wready) begin
      next_r.w_full = 1'b1;
      next_r.w_data = S_AXI_WDATA;
      next_r.w_strb = S_AXI_WSTRB;
    end
    if (S_AXI_BREADY && r.bvalid) begin
      next_r.bvalid = 1'b0;
    end

    // Perform a write once both halves are held
    if (r.aw_full && r.w_full && !r.bvalid) begin
      next_r.aw_full = 1'b0;
      next_r.w_full = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = sas_pkg::RESP_OKAY;
      case (r.aw_addr)
        sas_pkg::OFS_CTRL: begin
          wv = merge(ctrl_word, r.w_data, r.w_strb);
          next_r.override = wv[sas_pkg::CTRL_OVERRIDE];
          next_r.enable = wv[sas_pkg::CTRL_ENABLE];
          next_r.rate = wv[sas_pkg::CTRL_RATE_LSB +: 2];
          next_r.pair = wv[sas_pkg::CTRL_PAIR_LSB +: 3];
          next_r.single = wv[sas_pkg::CTRL_SINGLE];
          next_r.neg = wv[sas_pkg::CTRL_NEG];
          next_r.max256 = wv[sas_pkg::CTRL_MAX256];
        end
        sas_pkg::OFS_STATUS: begin
          // Write one to clear; a fill in this cycle wins below
          next_r.full = r.full & ~(r.w_data[7:0] & {8{r.w_strb[0]}});
        end
        sas_pkg::OFS_CFG_TEMP_PGA, sas_pkg::OFS_CFG_GROUP_A,
        sas_pkg::OFS_CFG_GROUP_B, sas_pkg::OFS_CFG_GROUP_C: begin
          // Group index wraps in two bits: 0x6c is 0, 0x70 to 0x78 are 1 to 3
          g = int'(2'(r.aw_addr[3:2] - sas_pkg::OFS_CFG_TEMP_PGA[3:2]));
          wv = merge(cfg_word(r.cfg, g), r.w_data, r.w_strb);
          next_r.cfg[2*g] = wv[CFG_BITS_L-1:0];
          next_r.cfg[2*g+1] = wv[16 +: CFG_BITS_L];
          next_r.done = '0;
        end
        default: next_r.bresp = sas_pkg::RESP_SLVERR;
      endcase
    end
    next_r.awready = !next_r.aw_full;
    next_r.wready = !next_r.w_full;

    // Reads answer one cycle after the address is taken
    if (S_AXI_RREADY && r.rvalid) begin
      next_r.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && r.arready) begin
      if (S_AXI_ARADDR[11]) begin
        rd_mem = 1'b1;
        rv = {16'h0000, mem[mem_ra]};
      end else begin
        case (S_AXI_ARADDR)
          sas_pkg::OFS_CTRL: rv = ctrl_word;
          sas_pkg::OFS_STATUS: begin
            rv[7:0] = r.full;
            rv[sas_pkg::STATUS_BUSY] = r.phase != sas_pkg::PH_IDLE;
          end
          sas_pkg::OFS_CFG_TEMP_PGA: rv = cfg_word(r.cfg, 0);
          sas_pkg::OFS_CFG_GROUP_A: rv = cfg_word(r.cfg, 1);
          sas_pkg::OFS_CFG_GROUP_B: rv = cfg_word(r.cfg, 2);
          sas_pkg::OFS_CFG_GROUP_C: rv = cfg_word(r.cfg, 3);
          default: rr = sas_pkg::RESP_SLVERR;
        endcase
      end
      next_r.rvalid = 1'b1;
      next_r.rdata = rv;
      next_r.rresp = rr;
    end
    next_r.arready = !next_r.rvalid;

    // One-shot bookkeeping only lives while sweep runs
    if (!r.enable || r.override) begin
      next_r.done = '0;
    end

    // Sequencer
    case (r.phase)
      sas_pkg::PH_IDLE: begin
        if (r.enable && r.override) begin
          // Manual: software pair, default differential
          next_r.chan = r.pair;
          next_r.diff = !r.single;
          next_r.nsel = r.single && r.neg;
          case (r.rate)
            2'h0: next_r.cnt = sas_pkg::TICKS_80K;
            2'h1: next_r.cnt = sas_pkg::TICKS_160K;
            default: next_r.cnt = sas_pkg::TICKS_320K;
          endcase
          next_r.phase = sas_pkg::PH_WAIT;
        end else if (r.enable) begin
          nx = pick(r.cfg, r.done, r.chan);
          if (nx[3]) begin
            // Odd halves are the negative-side inputs
            next_r.chan = nx[2:0];
            next_r.diff = r.cfg[nx[2:0]][sas_pkg::CFG_DIFF];
            next_r.nsel = nx[0] && !r.cfg[nx[2:0]][sas_pkg::CFG_DIFF];
            st_base = r.max256 ? sas_pkg::ST_BASE_256K
                               : sas_pkg::ST_BASE_320K;
            next_r.cnt = st_base + (7'(r.cfg[nx[2:0]][3:0])
                << sas_pkg::ST_STEP_SHIFT);
            next_r.phase = sas_pkg::PH_WAIT;
          end
        end
      end
      sas_pkg::PH_WAIT: begin
        if (!r.enable) begin
          next_r.phase = sas_pkg::PH_IDLE;
        end else if (r.tick) begin
          next_r.cnt = r.cnt - 7'h01;
          if (r.cnt <= 7'h01) begin
            next_r.start = 1'b1;
            next_r.phase = sas_pkg::PH_CONV;
          end
        end
      end
      sas_pkg::PH_CONV: begin
        if (CONV_VALID && r.conv_ready) begin
          push = 1'b1;
          if (!r.override && r.cfg[r.chan][sas_pkg::CFG_ONESHOT]) begin
            next_r.done[r.chan] = 1'b1;
          end
          next_r.phase = sas_pkg::PH_IDLE;
        end
      end
      default: next_r.phase = sas_pkg::PH_IDLE;
    endcase

    // Drain into memory; a sample read by software stalls it
    if (r.buf_cnt != 2'h0 && !rd_mem) begin
      pop = 1'b1;
      mem_we = 1'b1;
      next_r.widx[hc] = IW'(r.widx[hc] + 1'b1);
      if (&r.widx[hc]) begin
        next_r.full[hc] = 1'b1;
      end
      next_r.buf_head = !r.buf_head;
    end
    if (push) begin
      // Tail slot is buf_cnt past the head; a pop moves the head only
      next_r.buf_d[r.buf_head ^ r.buf_cnt[0]] = {r.chan, CONV_DATA};
    end
    next_r.buf_cnt = r.buf_cnt + 2'(push) - 2'(pop);
    next_r.conv_ready = next_r.buf_cnt != 2'h2;
  end

  // State register with synchronous reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= '0;
      r.override <= sas_pkg::CTRL_OVERRIDE_RST;
      r.rate <= sas_pkg::CTRL_RATE_RST;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.conv_ready <= 1'b1;
      r.phase <= sas_pkg::PH_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Sample memory write port, no reset needed for contents
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Outputs straight from state
  assign S_AXI_AWREADY = r.awready;
  assign S_AXI_WREADY = r.wready;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_ARREADY = r.arready;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RDATA = r.rdata;
  assign S_AXI_RRESP = r.rresp;
  assign CONV_START = r.start;
  assign CONV_CHAN = r.chan;
  assign CONV_DIFF = r.diff;
  assign CONV_NEG = r.nsel;
  assign CONV_READY = r.conv_ready;
endmodule

// ### tb/sas_top_chk.sv
module sas_top_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Write channels
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // Read channels
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Converter request
  input wire logic CONV_START,
  input wire logic [2:0] CONV_CHAN,
  input wire logic CONV_DIFF,
  input wire logic CONV_NEG
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // Both halves of a write taken at one edge
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // Read address taken
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_write_answer: assert property (
    wr_taken |-> ##[1:2] S_AXI_BVALID) else $error("write answer late");
  a_read_answer: assert property (
    rd_taken |=> S_AXI_RVALID) else $error("read answer late");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_read_single: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("second read accepted");
  a_refused_zero: assert property (
    S_AXI_RVALID && S_AXI_RRESP == sas_pkg::RESP_SLVERR |-> S_AXI_RDATA == 0)
    else $error("refused read carries data");
  a_start_spacing: assert property (
    CONV_START |=> !CONV_START [*8]) else $error("start pulses too close");
  // Selection must already be settled when the start pulse comes
  a_select_stable: assert property (
    CONV_START |-> $stable(CONV_CHAN) && $stable(CONV_DIFF)
    && $stable(CONV_NEG)) else $error("selection moved at start");
endmodule
bind sas_top sas_top_chk u_chk (
  .CLK(CLK), .RESET(RESET), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN), .CONV_DIFF(CONV_DIFF),
  .CONV_NEG(CONV_NEG)
);

// ### tb/sas_conv_model.sv
module sas_conv_model #(
  parameter int LAT = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request from the sequencer
  input wire logic start,
  input wire logic [2:0] chan,
  input wire logic diff,
  input wire logic neg,
  // Result handshake
  input wire logic ready,
  output logic valid = 1'b0,
  output logic [11:0] data = 12'h000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles left until the result appears
  int cnt = 0;
  // Result encodes the selection so the bench can find it in memory
  always @(posedge clk) begin
    if (reset) begin
      valid <= 1'b0;
      cnt <= 0;
    end else begin
      if (start) begin
        cnt <= LAT;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      if (cnt == 1) begin
        valid <= 1'b1;
        data <= {chan, diff, neg, 7'h5a};
      end else if (valid && ready) begin
        // Released bus shows no stale word
        valid <= 1'b0;
        data <= ~data;
      end
    end
  end
endmodule

// ### tb/sas_top_tb.sv
module sas_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus and converter wires
  logic clk = 1'b0, reset = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic conv_start, conv_diff, conv_neg, conv_valid, conv_ready, dif, ng;
  logic [2:0] conv_chan, ch;
  logic [11:0] conv_data;
  int fails = 0, cmp_count = 0, cyc = 0, since = 0, g, gp;
  always #10 clk = ~clk;
  sas_top i_dut (
    .CLK(clk), .RESET(reset), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CONV_START(conv_start), .CONV_CHAN(conv_chan),
    .CONV_DIFF(conv_diff), .CONV_NEG(conv_neg), .CONV_VALID(conv_valid),
    .CONV_DATA(conv_data), .CONV_READY(conv_ready)
  );
  sas_conv_model i_core (
    .clk(clk), .reset(reset), .start(conv_start), .chan(conv_chan),
    .diff(conv_diff), .neg(conv_neg), .ready(conv_ready),
    .valid(conv_valid), .data(conv_data)
  );
  // Cycles since the last result was taken, for wait checks
  always @(posedge clk) begin
    since <= (conv_valid && conv_ready) ? 0 : since + 1;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end
  task automatic check(input string w, input logic [31:0] s,
                       input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Next start pulse and the selection it carries
  task automatic nxt();
    do @(posedge clk); while (conv_start !== 1'b1);
    gp = since;
    ch = conv_chan;
    dif = conv_diff;
    ng = conv_neg;
  endtask
  // Tick phase is unknown, so allow one tick of slack below
  task automatic gap_chk(input int n);
    check("wait length", 32'(gp >= (n - 1) * 39 && gp <= n * 40 + 4), 32'h1);
  endtask
  task automatic final_report();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(sas_pkg::OFS_CTRL);
    check("ctrl reset", rv, 32'h9);
    rd(sas_pkg::OFS_STATUS);
    check("status reset", rv, 32'h0);
    // Configs reset clear, upper bits of each half stay zero
    for (g = 0; g < 4; g++) begin
      rd(sas_pkg::OFS_CFG_TEMP_PGA + 12'(4 * g));
      check("cfg reset", rv, 32'h0);
      wr(sas_pkg::OFS_CFG_TEMP_PGA + 12'(4 * g), 32'hffff_ffff);
      rd(sas_pkg::OFS_CFG_TEMP_PGA + 12'(4 * g));
      check("cfg mask", rv, 32'h007f_007f);
    end
    rd(12'h100);
    check("unmapped read", 32'(rs), 32'h2);
    wr(sas_pkg::OFS_SAMPLES, 32'h1);
    check("sample write", 32'(rs), 32'h2);
    $display("register test done");
    // Manual at each rate; all channel configs enabled but ignored
    for (g = 0; g < 3; g++) begin
      wr(sas_pkg::OFS_CTRL, 32'h33 | (32'(g) << 2));
      nxt();
      nxt();
      gap_chk(16 >> g);
      check("manual chan", 32'(ch), 32'h3);
      check("manual diff", 32'(dif), 32'h1);
    end
    rd(sas_pkg::OFS_SAMPLES + 12'h300);
    check("first sample", rv, 32'({3'h3, 1'b1, 1'b0, 7'h5a}));
    wr(sas_pkg::OFS_CTRL, 32'h1bb);
    nxt();
    nxt();
    check("single neg", 32'({dif, ng}), 32'h1);
    $display("manual test done");
    // Region of channel 3 fills after 64 samples
    do rd(sas_pkg::OFS_STATUS); while (rv[3] !== 1'b1);
    wr(sas_pkg::OFS_CTRL, 32'h1);
    rd(sas_pkg::OFS_STATUS);
    check("full flag", rv & 32'hff, 32'h8);
    wr(sas_pkg::OFS_STATUS, 32'hff);
    rd(sas_pkg::OFS_STATUS);
    check("flag clear", rv & 32'hff, 32'h0);
    $display("fill test done");
    // Sweep: ch1 one-shot single-ended, ch5 continuous differential
    wr(sas_pkg::OFS_CFG_TEMP_PGA, 32'h0050_0000);
    wr(sas_pkg::OFS_CFG_GROUP_A, 32'h0);
    wr(sas_pkg::OFS_CFG_GROUP_B, 32'h0031_0000);
    wr(sas_pkg::OFS_CFG_GROUP_C, 32'h0);
    wr(sas_pkg::OFS_CTRL, 32'h2);
    // Sweep resumes after the last manual pair (3), so ch5 comes first
    nxt();
    check("sweep lead", 32'({ch, dif}), 32'({3'h5, 1'b1}));
    nxt();
    check("sweep first", 32'({ch, dif, ng}), 32'({3'h1, 2'h1}));
    for (g = 0; g < 3; g++) begin
      nxt();
      check("sweep chan", 32'({ch, dif}), 32'({3'h5, 1'b1}));
      gap_chk(6);
    end
    wr(sas_pkg::OFS_CTRL, 32'h202);
    nxt();
    nxt();
    gap_chk(7);
    wr(sas_pkg::OFS_CTRL, 32'h0);
    rd(sas_pkg::OFS_SAMPLES + 12'h100);
    check("sweep sample", rv, 32'({3'h1, 1'b0, 1'b1, 7'h5a}));
    $display("sweep test done");
    final_report();
  end
endmodule
